// [common/tmr8_pkg.sv]
// tmr8_pkg: shared constants and carrier types for the 8-bit timer/counter.
// assumes one 250 MHz clock and a plain strobe-based register port.
package tmr8_pkg;
    // ----------------------------------------------------------------
    // register offsets (own map)
    // ----------------------------------------------------------------
    localparam logic [2:0] TMR8_ADDR_CTRL_A = 3'h0;  // comA, comB, wgm1:0
    localparam logic [2:0] TMR8_ADDR_CTRL_B = 3'h1;  // force a/b, wgm2, clock select
    localparam logic [2:0] TMR8_ADDR_COUNT = 3'h2;   // counter_value
    localparam logic [2:0] TMR8_ADDR_CMP_A = 3'h3;   // compare_a_value
    localparam logic [2:0] TMR8_ADDR_CMP_B = 3'h4;   // compare_b_value
    localparam logic [2:0] TMR8_ADDR_FLAGS = 3'h5;   // flags, write one to clear
    localparam logic [2:0] TMR8_ADDR_OUTS = 3'h6;    // compare output state, writable
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int TMR8_COMA_LSB = 6;
    localparam int TMR8_COMB_LSB = 4;
    localparam int TMR8_WGM_LSB = 0;
    localparam int TMR8_FOCA_BIT = 7;
    localparam int TMR8_FOCB_BIT = 6;
    localparam int TMR8_WGM2_BIT = 3;
    localparam int TMR8_CS_LSB = 0;
    localparam int TMR8_OVF_BIT = 0;
    localparam int TMR8_CMPA_BIT = 1;
    localparam int TMR8_CMPB_BIT = 2;
    localparam int TMR8_OCA_BIT = 0;  // output-state register, channel A
    localparam int TMR8_OCB_BIT = 1;  // output-state register, channel B
    // ----------------------------------------------------------------
    // values
    // ----------------------------------------------------------------
    localparam logic [7:0] TMR8_BOTTOM = 8'h00;
    localparam logic [7:0] TMR8_MAX = 8'hFF;
    localparam logic [7:0] TMR8_RESET_BYTE = 8'h00;
    localparam logic [1:0] TMR8_COM_OFF = 2'h0;
    localparam logic [1:0] TMR8_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TMR8_COM_CLEAR = 2'h2;
    localparam logic [1:0] TMR8_COM_SET = 2'h3;
    localparam logic [2:0] TMR8_WGM_NORMAL = 3'h0;
    localparam logic [2:0] TMR8_WGM_CTC = 3'h2;
    localparam logic [2:0] TMR8_WGM_FAST = 3'h3;
    localparam logic [2:0] TMR8_WGM_FAST_OCRA = 3'h7;
    // prescale divisors and clock selects
    localparam logic [2:0] TMR8_CS_STOP = 3'h0;
    localparam logic [2:0] TMR8_CS_DIV1 = 3'h1;
    localparam logic [2:0] TMR8_CS_DIV8 = 3'h2;
    localparam logic [2:0] TMR8_CS_DIV64 = 3'h3;
    localparam logic [2:0] TMR8_CS_DIV256 = 3'h4;
    localparam logic [2:0] TMR8_CS_DIV1024 = 3'h5;
    localparam logic [9:0] TMR8_PRE_8 = 10'h007;
    localparam logic [9:0] TMR8_PRE_64 = 10'h03F;
    localparam logic [9:0] TMR8_PRE_256 = 10'h0FF;
    localparam logic [9:0] TMR8_PRE_1024 = 10'h3FF;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmr8_bus_t;

    // one compare channel's pin view
    typedef struct packed {
        logic pin_value;
        logic pin_oe_n;
    } tmr8_pin_t;

    // whole state of the block
    typedef struct packed {
        logic [9:0] presc;
        logic [7:0] count;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [7:0] cmp_a_buf;
        logic [7:0] cmp_b_buf;
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [2:0] wgm;
        logic [2:0] cs;
        logic ovf;
        logic flag_a;
        logic flag_b;
        logic oc_a;
        logic oc_b;
        logic [7:0] rdata;
    } tmr8_state_t;
endpackage : tmr8_pkg

// [sim/tb.sv]
// tb: self-checking bench for the 8-bit timer/counter.
// assumes the register map and one-cycle read answer of the hand-over.
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ----------------------------------------------------------------
    // stimulus, outputs and bookkeeping
    // ----------------------------------------------------------------
    localparam logic [2:0] R_CA = tmr8_pkg::TMR8_ADDR_CTRL_A;
    localparam logic [2:0] R_CB = tmr8_pkg::TMR8_ADDR_CTRL_B;
    localparam logic [2:0] R_CNT = tmr8_pkg::TMR8_ADDR_COUNT;
    localparam logic [2:0] R_CMPA = tmr8_pkg::TMR8_ADDR_CMP_A;
    localparam logic [2:0] R_FLG = tmr8_pkg::TMR8_ADDR_FLAGS;
    localparam logic [2:0] R_OUT = tmr8_pkg::TMR8_ADDR_OUTS;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_q = 1'b0;
    logic rd_q = 1'b0;
    logic dir_a = 1'b0, dir_b = 1'b0, gpio_a = 1'b0, gpio_b = 1'b0;
    logic [7:0] rdata;
    logic ch_a, oe_a, ch_b, oe_b, ovf, fla, flb, tick;
    logic rd_seen = 1'b0;      // a read was taken at the last edge
    logic [7:0] exp_q [$];     // expected read answers, oldest first
    logic [1:0] coms [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic [7:0] outs [4] = '{8'h03, 8'h00, 8'h03, 8'h03};
    int divs [5] = '{1, 8, 64, 256, 1024};
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 20690;
    logic [7:0] rnd;
    logic [15:0] ticks;

    tmr8_timer i_tmr8_timer (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_q), .reg_rd_in(rd_q), .reg_rdata_out(rdata),
        .port_a_dir_in(dir_a), .port_b_dir_in(dir_b), .port_a_gpio_in(gpio_a),
        .port_b_gpio_in(gpio_b), .channel_a_output_out(ch_a), .channel_a_oe_n_out(oe_a),
        .channel_b_output_out(ch_b), .channel_b_oe_n_out(oe_b), .overflow_flag_out(ovf),
        .compare_a_flag_out(fla), .compare_b_flag_out(flb), .timer_tick_out(tick)
    );

    // 250 MHz clock
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end

    // ----------------------------------------------------------------
    // bus tasks and comparisons
    // ----------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wr_q <= 1'b1;
        @(posedge mclk_in);
        wr_q <= 1'b0;
    endtask : wr

    // the note goes in before the strobe is taken, so the watcher finds it
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        addr <= a;
        rd_q <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk_in);
        rd_q <= 1'b0;
    endtask : rd

    // run exactly t ticks at divide-by-one; the stop write keeps the mode bit
    task automatic run(input int t, input logic [7:0] csb);
        wr(R_CB, csb);
        repeat (t - 2) @(posedge mclk_in);
        wr(R_CB, csb & 8'h08);
    endtask : run

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_read(input logic [7:0] got, input logic [7:0] exp);
        check_val({8'h00, got}, {8'h00, exp});
    endtask : check_read

    task automatic print_verdict;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // read answers are settled by the falling edge after the taken read
    always @(posedge mclk_in) rd_seen <= rd_q && reset_n_in;
    always @(negedge mclk_in) begin
        if (rd_seen) begin
            check_read(rdata, exp_q.pop_front());
        end
    end

    // watchdog, well beyond the roughly 11k cycles the run needs
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), 8'h00);
        end
        for (int a = 2; a < 5; a++) begin
            rnd = 8'($random(seed));
            wr(3'(a), rnd);
            rd(3'(a), rnd);
        end
        wr(3'h7, 8'h5A);
        rd(3'h7, 8'h00);
        // compares parked mid-range so the wrap test sees no match
        wr(R_CMPA, 8'h80);
        wr(R_CMPA + 3'h1, 8'h80);
        wr(R_CNT, 8'hFD);
        run(3, 8'h01);
        rd(R_CNT, 8'h00);
        rd(R_FLG, 8'h01);
        run(2, 8'h01);
        rd(R_FLG, 8'h01);
        wr(R_FLG, 8'h07);
        rd(R_FLG, 8'h00);
        // forced actions for every non-PWM code, pins against random gpio
        wr(R_OUT, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd = 8'($random(seed));
            {dir_b, gpio_b, dir_a, gpio_a} <= rnd[3:0];
            wr(R_CA, {coms[i], coms[i], 4'h0});
            wr(R_CB, 8'hC0);
            rd(R_OUT, outs[i]);
            @(negedge mclk_in);
            check_val(16'(ch_a), (i < 3) ? 16'(outs[i][0]) : 16'(rnd[0]));
            check_val(16'(ch_b), (i < 3) ? 16'(outs[i][1]) : 16'(rnd[2]));
        end
        // clear-on-match with toggle on channel A, top 4
        dir_a <= 1'b1;
        wr(R_CMPA, 8'h04);
        wr(R_CNT, 8'h00);
        wr(R_OUT, 8'h00);
        wr(R_FLG, 8'h07);
        wr(R_CA, 8'h42);
        run(7, 8'h01);
        rd(R_CNT, 8'h02);
        rd(R_FLG, 8'h02);
        rd(R_OUT, 8'h01);
        check_val(16'(ch_a), 16'h0001);
        // counter above the top misses it and wraps
        wr(R_CNT, 8'h0A);
        wr(R_FLG, 8'h07);
        run(246, 8'h01);
        rd(R_CNT, 8'h00);
        rd(R_FLG, 8'h05);
        // fast PWM, top at max: A non-inverted, B inverted
        wr(R_CA, 8'h00);
        wr(R_CMPA, 8'h10);
        wr(R_CMPA + 3'h1, 8'h10);
        wr(R_CNT, 8'h00);
        wr(R_OUT, 8'h00);
        wr(R_FLG, 8'h07);
        wr(R_CA, 8'hB3);
        run(17, 8'h01);
        rd(R_OUT, 8'h02);
        rd(R_FLG, 8'h06);
        run(240, 8'h01);
        rd(R_CNT, 8'h01);
        rd(R_OUT, 8'h01);
        rd(R_FLG, 8'h07);
        // fast PWM, top from compare A, toggle on A
        wr(R_CA, 8'h00);
        wr(R_CMPA, 8'h05);
        wr(R_CNT, 8'h00);
        wr(R_OUT, 8'h00);
        wr(R_CA, 8'h43);
        run(8, 8'h09);
        rd(R_CNT, 8'h02);
        rd(R_OUT, 8'h01);
        // a lower top written mid-period waits for the next top
        wr(R_CMPA, 8'h02);
        run(3, 8'h09);
        rd(R_CNT, 8'h05);
        // every prescale factor over a window that all divide evenly
        for (int i = 0; i < 5; i++) begin
            wr(R_CB, 8'(i + 1));
            ticks = 16'h0000;
            repeat (2048) begin
                @(negedge mclk_in);
                ticks = ticks + 16'(tick);
            end
            check_val(ticks, 16'(2048 / divs[i]));
        end
        wr(R_CB, 8'h00);
        repeat (2) @(posedge mclk_in);
        print_verdict();
    end
endmodule : tb
`default_nettype wire

// [sim/tmr8_timer_monitor.sv]
// tmr8_timer_monitor: port-level assertions for the 8-bit timer/counter.
// assumes the flag and read-data timing of the register port hand-over.
`timescale 1ns/1ps
`default_nettype none

module tmr8_timer_monitor (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // pins
    input wire logic port_a_dir_in,
    input wire logic port_b_dir_in,
    input wire logic channel_a_oe_n_out,
    input wire logic channel_b_oe_n_out,
    // flags and tick
    input wire logic overflow_flag_out,
    input wire logic compare_a_flag_out,
    input wire logic compare_b_flag_out,
    input wire logic timer_tick_out
);
    // ----------------------------------------------------------------
    // one clock domain, so one default clocking and disable
    // ----------------------------------------------------------------
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    pin_dir_a_a: assert property (channel_a_oe_n_out == !port_a_dir_in)
        else $error("pin a enable does not follow direction");
    pin_dir_b_a: assert property (channel_b_oe_n_out == !port_b_dir_in)
        else $error("pin b enable does not follow direction");
    // read data only stands in the cycle after a read strobe
    rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read answer");
    rd_flags_a: assert property (reg_rd_in && reg_addr_in == tmr8_pkg::TMR8_ADDR_FLAGS
        |=> reg_rdata_out == {5'h00, $past(compare_b_flag_out), $past(compare_a_flag_out),
        $past(overflow_flag_out)})
        else $error("flag read does not show flag pins");
    // counting only sets the flags, software clears them
    ovf_sticky_a: assert property (overflow_flag_out && !(reg_wr_in
        && reg_addr_in == tmr8_pkg::TMR8_ADDR_FLAGS && reg_wdata_in[0]) |=> overflow_flag_out)
        else $error("overflow flag dropped without a clear");
    cmpa_sticky_a: assert property (compare_a_flag_out && !(reg_wr_in
        && reg_addr_in == tmr8_pkg::TMR8_ADDR_FLAGS && reg_wdata_in[1]) |=> compare_a_flag_out)
        else $error("compare a flag dropped without a clear");
    ovf_tick_a: assert property ($rose(overflow_flag_out) |-> $past(timer_tick_out))
        else $error("overflow flag rose without a timer tick");
    reset_clear_a: assert property ($rose(reset_n_in) |-> !overflow_flag_out
        && !compare_a_flag_out && !compare_b_flag_out && !timer_tick_out)
        else $error("state not cleared after reset");
endmodule : tmr8_timer_monitor

bind tmr8_timer tmr8_timer_monitor i_tmr8_timer_monitor (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .port_a_dir_in(port_a_dir_in),
    .port_b_dir_in(port_b_dir_in), .channel_a_oe_n_out(channel_a_oe_n_out),
    .channel_b_oe_n_out(channel_b_oe_n_out), .overflow_flag_out(overflow_flag_out),
    .compare_a_flag_out(compare_a_flag_out), .compare_b_flag_out(compare_b_flag_out),
    .timer_tick_out(timer_tick_out)
);
`default_nettype wire

// [verilog/tmr8_timer.sv]
// tmr8_timer: 8-bit timer/counter with two compare channels (A, B),
// normal, clear-on-match and fast PWM waveform modes.
// assumes all inputs synchronous to mclk_in; the port-direction bits
// come from the surrounding GPIO block.
//
// Summary of operation
// - compare mode zero leaves output untouched
// - new compare mode acts from next match
// - force strobe applies action in non-PWM
// - counting depends only on waveform mode
// - mode 0 counts up, wraps FF to 00
// - normal mode overflow set when count hits zero
// - counter writable anytime in normal mode
// - mode 2 clears counter on compare A
// - clear-on-match sets compare A flag at top
// - unbuffered compare A may miss match
// - clear-on-match compare mode 1 toggles A
// - pin driven only when direction is output
// - clear-on-match overflow at MAX to 00
// - prescale 1, 8, 64, 256, 1024
// - modes 3/7 single slope, top FF or A
// - fast PWM clear on match, set at bottom
// - compare mode 2 normal, 3 inverted PWM
// - fast PWM toggle A only with bit2
// - fast PWM clears the cycle after top
// - fast PWM overflow set at top
// - output state loadable before enabling pin
// - non-PWM encodings off, toggle, clear, set
// - nonzero compare mode overrides port output
// - fast PWM compare values double buffered
`timescale 1ns/1ps
`default_nettype none

module tmr8_timer #(
    parameter int COUNT_WIDTH = 8  // counter width; only 8 is served
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // port side
    input wire logic port_a_dir_in,   // pin_direction_bit, high = output
    input wire logic port_b_dir_in,
    input wire logic port_a_gpio_in,  // normal port value when not overridden
    input wire logic port_b_gpio_in,
    output logic channel_a_output_out,
    output logic channel_a_oe_n_out,
    output logic channel_b_output_out,
    output logic channel_b_oe_n_out,
    // flags and enable for the interrupt controller outside
    output logic overflow_flag_out,
    output logic compare_a_flag_out,
    output logic compare_b_flag_out,
    output logic timer_tick_out
);
    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (COUNT_WIDTH != 8) begin : g_bad_width
        $error("tmr8_timer only supports an 8-bit counter");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // pwm modes are those with both low mode bits set
    function automatic logic is_pwm(input logic [2:0] wgm);
        is_pwm = (wgm == tmr8_pkg::TMR8_WGM_FAST) || (wgm == tmr8_pkg::TMR8_WGM_FAST_OCRA);
    endfunction : is_pwm

    // non-PWM action on a compare output for a given compare mode
    function automatic logic non_pwm_action(input logic [1:0] com, input logic oc);
        case (com)
            tmr8_pkg::TMR8_COM_TOGGLE: non_pwm_action = ~oc;
            tmr8_pkg::TMR8_COM_CLEAR: non_pwm_action = 1'b0;
            tmr8_pkg::TMR8_COM_SET: non_pwm_action = 1'b1;
            default: non_pwm_action = oc;
        endcase
    endfunction : non_pwm_action

    tmr8_pkg::tmr8_state_t s_q;  // registered state
    tmr8_pkg::tmr8_state_t s_d;  // next state
    tmr8_pkg::tmr8_bus_t bus;    // bundled request

    assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    // working terms, filled in the comb process
    logic tick;          // timer clock enable
    logic pwm;           // fast PWM selected
    logic [7:0] top;     // current top value
    logic [7:0] eff_a;   // compare A seen by the matcher
    logic [7:0] eff_b;   // compare B seen by the matcher
    logic at_top;        // counter equals top
    logic match_a;       // compare A match this tick
    logic match_b;       // compare B match this tick
    logic wr_count;      // software writing the counter
    logic force_a;       // force strobe A
    logic force_b;       // force strobe B
    logic set_ovf;       // overflow event
    logic [7:0] rd_mux;  // read data next cycle

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        case (s_q.cs)
            tmr8_pkg::TMR8_CS_DIV1: tick = 1'b1;
            tmr8_pkg::TMR8_CS_DIV8: tick = (s_q.presc & tmr8_pkg::TMR8_PRE_8) == tmr8_pkg::TMR8_PRE_8;
            tmr8_pkg::TMR8_CS_DIV64: tick = (s_q.presc & tmr8_pkg::TMR8_PRE_64) == tmr8_pkg::TMR8_PRE_64;
            tmr8_pkg::TMR8_CS_DIV256: tick = (s_q.presc & tmr8_pkg::TMR8_PRE_256) == tmr8_pkg::TMR8_PRE_256;
            tmr8_pkg::TMR8_CS_DIV1024: tick = s_q.presc == tmr8_pkg::TMR8_PRE_1024;
            default: tick = 1'b0;  // stopped or reserved select
        endcase
        // free-running prescaler; wraps at 1024
        s_d.presc = s_q.presc + 10'h001;

        pwm = is_pwm(s_q.wgm);
        // clear-on-match uses the live value, so a late write misses
        eff_a = pwm ? s_q.cmp_a_buf : s_q.cmp_a;
        eff_b = pwm ? s_q.cmp_b_buf : s_q.cmp_b;
        // top is MAX in mode 3, compare A in mode 7
        case (s_q.wgm)
            tmr8_pkg::TMR8_WGM_CTC: top = s_q.cmp_a;
            tmr8_pkg::TMR8_WGM_FAST_OCRA: top = s_q.cmp_a_buf;
            default: top = tmr8_pkg::TMR8_MAX;
        endcase
        at_top = s_q.count == top;
        wr_count = bus.wr && (bus.addr == tmr8_pkg::TMR8_ADDR_COUNT);
        // a software counter write blocks a match in that cycle
        match_a = tick && !wr_count && (s_q.count == eff_a);
        match_b = tick && !wr_count && (s_q.count == eff_b);
        force_a = bus.wr && (bus.addr == tmr8_pkg::TMR8_ADDR_CTRL_B)
                  && bus.wdata[tmr8_pkg::TMR8_FOCA_BIT] && !pwm;
        force_b = bus.wr && (bus.addr == tmr8_pkg::TMR8_ADDR_CTRL_B)
                  && bus.wdata[tmr8_pkg::TMR8_FOCB_BIT] && !pwm;
        set_ovf = 1'b0;

        // counter; sequence from waveform mode only
        if (tick && !wr_count) begin
            case (s_q.wgm)
                tmr8_pkg::TMR8_WGM_CTC: begin
                    if (at_top) begin
                        s_d.count = tmr8_pkg::TMR8_BOTTOM;
                    end else begin
                        s_d.count = s_q.count + 8'h01;
                    end
                    // overflow only on MAX to 00
                    set_ovf = (s_q.count == tmr8_pkg::TMR8_MAX);
                end
                tmr8_pkg::TMR8_WGM_FAST, tmr8_pkg::TMR8_WGM_FAST_OCRA: begin
                    // clear on the tick after top
                    if (at_top) begin
                        s_d.count = tmr8_pkg::TMR8_BOTTOM;
                        s_d.cmp_a_buf = s_q.cmp_a;
                        s_d.cmp_b_buf = s_q.cmp_b;
                    end else begin
                        s_d.count = s_q.count + 8'h01;
                    end
                    set_ovf = at_top;
                end
                default: begin
                    // always up, wrap FF to 00
                    s_d.count = s_q.count + 8'h01;
                    set_ovf = (s_q.count == tmr8_pkg::TMR8_MAX);
                end
            endcase
        end

        // ---- compare outputs
        if (pwm) begin
            // mode 2 non-inverted, mode 3 inverted
            // match clears (or sets), bottom sets (or clears)
            if (s_q.com_a[1]) begin
                if (match_a) begin
                    s_d.oc_a = s_q.com_a[0];
                end else if (tick && at_top) begin
                    s_d.oc_a = ~s_q.com_a[0];
                end
            end else if (s_q.com_a == tmr8_pkg::TMR8_COM_TOGGLE && s_q.wgm[2] && match_a) begin
                // toggle on A only with mode bit 2
                s_d.oc_a = ~s_q.oc_a;
            end
            // channel B has no toggle choice in PWM
            if (s_q.com_b[1]) begin
                if (match_b) begin
                    s_d.oc_b = s_q.com_b[0];
                end else if (tick && at_top) begin
                    s_d.oc_b = ~s_q.com_b[0];
                end
            end
        end else begin
            // toggle via mode 1 in clear-on-match
            if (match_a || force_a) begin
                s_d.oc_a = non_pwm_action(s_q.com_a, s_q.oc_a);
            end
            if (match_b || force_b) begin
                s_d.oc_b = non_pwm_action(s_q.com_b, s_q.oc_b);
            end
        end

        // ---- flags; set wins over a clear in the same cycle
        if (bus.wr && bus.addr == tmr8_pkg::TMR8_ADDR_FLAGS) begin
            if (bus.wdata[tmr8_pkg::TMR8_OVF_BIT]) begin
                s_d.ovf = 1'b0;
            end
            if (bus.wdata[tmr8_pkg::TMR8_CMPA_BIT]) begin
                s_d.flag_a = 1'b0;
            end
            if (bus.wdata[tmr8_pkg::TMR8_CMPB_BIT]) begin
                s_d.flag_b = 1'b0;
            end
        end
        if (set_ovf) begin
            s_d.ovf = 1'b1;
        end
        // compare A flag at match (top in clear-on-match)
        if (match_a) begin
            s_d.flag_a = 1'b1;
        end
        if (match_b) begin
            s_d.flag_b = 1'b1;
        end

        // register writes; new modes act from next match
        if (bus.wr) begin
            case (bus.addr)
                tmr8_pkg::TMR8_ADDR_CTRL_A: begin
                    s_d.com_a = bus.wdata[tmr8_pkg::TMR8_COMA_LSB +: 2];
                    s_d.com_b = bus.wdata[tmr8_pkg::TMR8_COMB_LSB +: 2];
                    s_d.wgm[1:0] = bus.wdata[tmr8_pkg::TMR8_WGM_LSB +: 2];
                end
                tmr8_pkg::TMR8_ADDR_CTRL_B: begin
                    s_d.wgm[2] = bus.wdata[tmr8_pkg::TMR8_WGM2_BIT];
                    s_d.cs = bus.wdata[tmr8_pkg::TMR8_CS_LSB +: 3];
                end
                tmr8_pkg::TMR8_ADDR_COUNT: s_d.count = bus.wdata;
                tmr8_pkg::TMR8_ADDR_CMP_A: s_d.cmp_a = bus.wdata;
                tmr8_pkg::TMR8_ADDR_CMP_B: s_d.cmp_b = bus.wdata;
                tmr8_pkg::TMR8_ADDR_OUTS: begin
                    s_d.oc_a = bus.wdata[tmr8_pkg::TMR8_OCA_BIT];
                    s_d.oc_b = bus.wdata[tmr8_pkg::TMR8_OCB_BIT];
                end
                default: ;  // flags handled above, others ignored
            endcase
        end
        // outside PWM the buffers follow so entry into PWM starts clean
        if (!is_pwm(s_d.wgm) || !pwm) begin
            s_d.cmp_a_buf = s_d.cmp_a;
            s_d.cmp_b_buf = s_d.cmp_b;
        end

        // ---- read data, valid the cycle after the strobe
        case (bus.addr)
            tmr8_pkg::TMR8_ADDR_CTRL_A: rd_mux = {s_q.com_a, s_q.com_b, 2'h0, s_q.wgm[1:0]};
            tmr8_pkg::TMR8_ADDR_CTRL_B: rd_mux = {4'h0, s_q.wgm[2], s_q.cs};
            tmr8_pkg::TMR8_ADDR_COUNT: rd_mux = s_q.count;
            tmr8_pkg::TMR8_ADDR_CMP_A: rd_mux = s_q.cmp_a;
            tmr8_pkg::TMR8_ADDR_CMP_B: rd_mux = s_q.cmp_b;
            tmr8_pkg::TMR8_ADDR_FLAGS: rd_mux = {5'h00, s_q.flag_b, s_q.flag_a, s_q.ovf};
            tmr8_pkg::TMR8_ADDR_OUTS: rd_mux = {6'h00, s_q.oc_b, s_q.oc_a};
            default: rd_mux = 8'h00;  // unmapped reads zero
        endcase
        s_d.rdata = bus.rd ? rd_mux : 8'h00;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata_out = s_q.rdata;
    // nonzero compare mode overrides the port value
    assign channel_a_output_out = (s_q.com_a != tmr8_pkg::TMR8_COM_OFF) ? s_q.oc_a : port_a_gpio_in;
    assign channel_b_output_out = (s_q.com_b != tmr8_pkg::TMR8_COM_OFF) ? s_q.oc_b : port_b_gpio_in;
    // drive only when the direction bit says output
    assign channel_a_oe_n_out = ~port_a_dir_in;
    assign channel_b_oe_n_out = ~port_b_dir_in;
    assign overflow_flag_out = s_q.ovf;
    assign compare_a_flag_out = s_q.flag_a;
    assign compare_b_flag_out = s_q.flag_b;
    assign timer_tick_out = tick;
endmodule : tmr8_timer

`default_nettype wire
